/* File: mric_ctrl.sv */
`timescale 1ns/1ps
module mric_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire mric_pkg::mric_bus_t bus,
  output logic [7:0] bus_rdata,
  // core side
  input wire mric_pkg::mric_core_req_t core,
  input wire logic timer_event,
  output logic [14:0] program_counter,
  output logic [7:0] stack_pointer,
  output mric_pkg::mric_stack_wr_t stack_wr,
  output logic instr_tick,
  output logic core_stall,
  output logic halted,
  output logic irq_request,
  // pins
  input wire mric_pkg::mric_clk_opt_t clk_option,
  input wire logic clock_out_wake_pin,
  input wire logic [7:0] port_l_in,
  input wire logic [7:0] port_g_in,
  input wire logic [7:0] port_c_in,
  output mric_pkg::mric_pins_t port_l,
  output mric_pkg::mric_pins_t port_g,
  output mric_pkg::mric_pins_t port_c,
  output logic [7:0] port_d
);
  import mric_pkg::*;

  typedef struct packed {
    logic [7:0] l_data;
    logic [7:0] l_cfg;
    logic [7:0] g_data;
    logic [7:0] g_cfg;
    logic [7:0] c_data;
    logic [7:0] c_cfg;
    logic [7:0] d_data;
    logic global_irq_enable;
    logic external_irq_enable;
    logic timer_irq_enable;
    logic external_irq_pending;
    logic timer_irq_pending;
    logic busy;
    logic [7:0] control_word;
    logic [14:0] prog;
    logic [7:0] stack;
    mric_state_t state;
    logic [3:0] div;
    logic [2:0] step;
    logic seq_soft;
    logic soft_pend;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic wake_s1;
    logic wake_s2;
    logic wake_s3;
    logic [7:0] rdata;
    mric_stack_wr_t push;
  } mric_state_vec_t;

  mric_state_vec_t st_q;
  mric_state_vec_t st_d;
  logic tick;
  logic wake_ok;
  logic wake_rise;
  logic ext_hit;
  logic ack;
  logic [7:0] status_byte;

  function automatic logic [7:0] byte_of(input logic [14:0] v, input logic hi);
    byte_of = hi ? 8'(v >> DATA_W) : v[7:0];
  endfunction : byte_of

  always_comb begin
    // crystal option owns the wake pin as oscillator output
    wake_ok = (clk_option != CLK_CRYSTAL);
    // only the second and third stages feed edge logic
    wake_rise = wake_ok & st_q.wake_s2 & ~st_q.wake_s3;
    ext_hit = st_q.control_word[CTL_EDGE_SEL]
      ? (~st_q.ext_s2 & st_q.ext_s3)
      : (st_q.ext_s2 & ~st_q.ext_s3);
    // halt stops the divider, hence every instruction cycle
    tick = (st_q.state != ST_HALT) && (st_q.div == DIV_LAST);
    irq_request = st_q.global_irq_enable
      & ((st_q.external_irq_enable & st_q.external_irq_pending)
      | (st_q.timer_irq_enable & st_q.timer_irq_pending));
    ack = (st_q.state == ST_RUN) && tick && core.boundary
      && (st_q.soft_pend || irq_request);
    status_byte = '0;
    status_byte[ST_GLOBAL_EN] = st_q.global_irq_enable;
    status_byte[ST_EXT_EN] = st_q.external_irq_enable;
    status_byte[ST_BUSY] = st_q.busy;
    status_byte[ST_EXT_PEND] = st_q.external_irq_pending;
    status_byte[ST_TMR_EN] = st_q.timer_irq_enable;
    status_byte[ST_TMR_PEND] = st_q.timer_irq_pending;
  end

  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.push.wr = 1'b0;
      st_d.rdata = '0;
      st_d.ext_s1 = port_g_in[EXT_PIN_BIT];
      st_d.ext_s2 = st_q.ext_s1;
      st_d.ext_s3 = st_q.ext_s2;
      st_d.wake_s1 = clock_out_wake_pin;
      st_d.wake_s2 = st_q.wake_s1;
      st_d.wake_s3 = st_q.wake_s2;
      if (st_q.state != ST_HALT) begin
        st_d.div = tick ? '0 : st_q.div + 4'h1;
      end
      if (bus.rd) begin
        unique case (bus.addr)
          REG_L_DATA: st_d.rdata = st_q.l_data;
          REG_L_CFG: st_d.rdata = st_q.l_cfg;
          REG_L_PINS: st_d.rdata = port_l_in;
          REG_G_DATA: st_d.rdata = st_q.g_data;
          REG_G_CFG: st_d.rdata = st_q.g_cfg & ~INPUT_ONLY_MASK;
          REG_G_PINS: begin
            st_d.rdata = port_g_in;
            st_d.rdata[WAKE_BIT] = wake_ok & st_q.wake_s2;
          end
          REG_C_DATA: st_d.rdata = st_q.c_data & PORT_C_MASK;
          REG_C_CFG: st_d.rdata = st_q.c_cfg & PORT_C_MASK;
          REG_C_PINS: st_d.rdata = port_c_in & PORT_C_MASK;
          REG_D_DATA: st_d.rdata = st_q.d_data;
          REG_STATUS: st_d.rdata = status_byte;
          REG_CONTROL: st_d.rdata = st_q.control_word;
          REG_STACK: st_d.rdata = st_q.stack;
          REG_PROG_LO: st_d.rdata = byte_of(st_q.prog, 1'b0);
          REG_PROG_HI: st_d.rdata = byte_of(st_q.prog, 1'b1);
          default: st_d.rdata = '0;
        endcase
      end
      unique case (st_q.state)
        ST_RUN: begin
          if (core.prog_load) begin
            st_d.prog = core.prog_value;
          end else if (core.prog_inc) begin
            st_d.prog = st_q.prog + PROG_STEP;
          end
          if (core.ret) begin
            st_d.prog = core.ret_value;
            st_d.stack = st_q.stack + STACK_STEP;
            if (core.return_from_interrupt) begin
              st_d.global_irq_enable = 1'b1;
            end
          end
          if (ack) begin
            st_d.state = ST_SEQ;
            st_d.step = '0;
            // opcode zero wins: it cannot be masked
            st_d.seq_soft = st_q.soft_pend;
            st_d.soft_pend = 1'b0;
            if (!st_q.soft_pend) begin
              st_d.global_irq_enable = 1'b0;
            end
          end
        end
        ST_SEQ: begin
          if (tick) begin
            if (st_q.step == PUSH_LO_STEP || st_q.step == PUSH_HI_STEP) begin
              st_d.push.wr = 1'b1;
              st_d.push.addr = st_q.stack - 8'(st_q.step);
              st_d.push.data = byte_of(st_q.prog, st_q.step[0]);
            end
            if (st_q.step == SEQ_LAST) begin
              st_d.prog = IRQ_VECTOR;
              st_d.stack = st_q.stack - STACK_STEP;
              st_d.state = ST_RUN;
            end else begin
              st_d.step = st_q.step + 3'h1;
            end
          end
        end
        ST_HALT: begin
          if (wake_rise) begin
            st_d.state = ST_RUN;
            st_d.g_data[WAKE_BIT] = 1'b0;
          end
        end
        default: st_d.state = ST_RUN;
      endcase
      if (bus.wr) begin
        unique case (bus.addr)
          REG_L_DATA: st_d.l_data = bus.wdata;
          REG_L_CFG: st_d.l_cfg = bus.wdata;
          REG_G_DATA: begin
            st_d.g_data = bus.wdata;
            if (bus.wdata[WAKE_BIT]) begin
              st_d.state = ST_HALT;
            end
          end
          REG_G_CFG: st_d.g_cfg = bus.wdata & ~INPUT_ONLY_MASK;
          REG_C_DATA: st_d.c_data = bus.wdata & PORT_C_MASK;
          REG_C_CFG: st_d.c_cfg = bus.wdata & PORT_C_MASK;
          REG_D_DATA: st_d.d_data = bus.wdata;
          REG_STATUS: begin
            st_d.global_irq_enable = bus.wdata[ST_GLOBAL_EN];
            st_d.external_irq_enable = bus.wdata[ST_EXT_EN];
            st_d.timer_irq_enable = bus.wdata[ST_TMR_EN];
            st_d.busy = bus.wdata[ST_BUSY];
            st_d.external_irq_pending = bus.wdata[ST_EXT_PEND];
            st_d.timer_irq_pending = bus.wdata[ST_TMR_PEND];
          end
          REG_CONTROL: st_d.control_word = bus.wdata;
          REG_STACK: st_d.stack = bus.wdata;
          default: st_d.l_data = st_d.l_data;
        endcase
      end
      // a source event beats a software clear in the same cycle
      if (ext_hit) begin
        st_d.external_irq_pending = 1'b1;
      end
      if (timer_event) begin
        st_d.timer_irq_pending = 1'b1;
      end
      if (core.soft_irq && st_q.state == ST_RUN) begin
        st_d.soft_pend = 1'b1;
      end
    end
    // reset acts as a level and overrides the clock enable
    if (!resetn) begin
      st_d = '0;
      st_d.prog = RESET_VECTOR;
      st_d.d_data = PORT_D_RESET;
      st_d.state = ST_RUN;
      // preload from the pins so a pin idling high gives no false edge
      st_d.ext_s1 = port_g_in[EXT_PIN_BIT];
      st_d.ext_s2 = port_g_in[EXT_PIN_BIT];
      st_d.ext_s3 = port_g_in[EXT_PIN_BIT];
      st_d.wake_s1 = clock_out_wake_pin;
      st_d.wake_s2 = clock_out_wake_pin;
      st_d.wake_s3 = clock_out_wake_pin;
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign bus_rdata = st_q.rdata;
  assign program_counter = st_q.prog;
  assign stack_pointer = st_q.stack;
  assign stack_wr = st_q.push;
  assign instr_tick = tick & clk_en;
  assign core_stall = (st_q.state != ST_RUN);
  assign halted = (st_q.state == ST_HALT);
  // pins float and port d goes high for as long as reset is low
  assign port_d = resetn ? st_q.d_data : PORT_D_RESET;
  assign port_l.out = st_q.l_data;
  assign port_l.oe = resetn ? st_q.l_cfg : '0;
  assign port_g.out = st_q.g_data;
  assign port_g.oe = resetn ? (st_q.g_cfg & ~INPUT_ONLY_MASK) : '0;
  assign port_c.out = st_q.c_data & PORT_C_MASK;
  assign port_c.oe = resetn ? (st_q.c_cfg & PORT_C_MASK) : '0;

  // helper: instruction cycles counted across an acknowledge
  logic [3:0] seq_ticks;
  always_ff @(posedge clock) begin
    if (!resetn || (clk_en && ack)) begin
      seq_ticks <= '0;
    end else if (clk_en && tick && st_q.state == ST_SEQ) begin
      seq_ticks <= seq_ticks + 4'h1;
    end
  end

  sequence s_ack_hw;
    clk_en && ack && !st_q.soft_pend;
  endsequence
  sequence s_seq_end;
    clk_en && tick && st_q.state == ST_SEQ && st_q.step == SEQ_LAST && !bus.wr;
  endsequence
  // a quiet boundary: only a maskable source could start a sequence here
  sequence s_quiet_boundary;
    clk_en && tick && core.boundary && st_q.state == ST_RUN && !st_q.soft_pend && !bus.wr;
  endsequence

  a_cfg_read_zero: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && bus.rd && bus.addr == REG_G_CFG |=> bus_rdata[7:6] == 2'h0)
    else $error("input-only config bits read nonzero");
  a_halt_entry: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && bus.wr && bus.addr == REG_G_DATA && bus.wdata[WAKE_BIT] |=> halted)
    else $error("halt not entered on data write");
  a_reset_drive: assert property (@(posedge clock)
    !resetn |-> port_d == PORT_D_RESET && port_l.oe == '0 && port_g.oe == '0)
    else $error("reset pins wrong");
  a_init_state: assert property (@(posedge clock)
    !resetn |=> program_counter == RESET_VECTOR && !halted && status_byte == '0)
    else $error("initialisation incomplete");
  a_halt_freeze: assert property (@(posedge clock) disable iff (!resetn)
    halted && !wake_rise && !(clk_en && bus.wr) |=> halted && $stable(program_counter)
      && $stable(stack_pointer) && !instr_tick)
    else $error("state moved while halted");
  a_reset_halt_exit: assert property (@(posedge clock)
    halted && !resetn |=> !halted && program_counter == RESET_VECTOR)
    else $error("reset did not leave halt");
  a_wake_exit: assert property (@(posedge clock) disable iff (!resetn)
    halted && wake_rise && clk_en && !bus.wr |=> !halted && !st_q.g_data[WAKE_BIT]
      && program_counter == $past(program_counter))
    else $error("wake did not resume cleanly");
  a_ack_clears_en: assert property (@(posedge clock) disable iff (!resetn)
    s_ack_hw and (!bus.wr) |=> !st_q.global_irq_enable ##0 core_stall)
    else $error("global enable kept on acknowledge");
  a_ack_gated: assert property (@(posedge clock) disable iff (!resetn)
    s_quiet_boundary ##0 (!st_q.global_irq_enable) |=> !core_stall)
    else $error("maskable taken while disabled");
  a_src_masked: assert property (@(posedge clock) disable iff (!resetn)
    s_quiet_boundary ##0 (!st_q.external_irq_enable && !st_q.timer_irq_enable) |=> !core_stall)
    else $error("masked source taken");
  a_edge_pend: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && st_q.ext_s2 != st_q.ext_s3
      && st_q.ext_s3 == st_q.control_word[CTL_EDGE_SEL] |=> st_q.external_irq_pending)
    else $error("selected edge lost");
  a_vector_seven: assert property (@(posedge clock) disable iff (!resetn)
    s_seq_end |=> program_counter == IRQ_VECTOR && !core_stall
      && stack_pointer == $past(stack_pointer) - STACK_STEP && seq_ticks == 4'(SEQ_CYCLES))
    else $error("vector sequence wrong");
  a_soft_keeps_en: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && ack && st_q.soft_pend && !bus.wr && !core.ret
      |=> st_q.global_irq_enable == $past(st_q.global_irq_enable))
    else $error("software interrupt changed enable");
  a_return_from_interrupt_sets_en: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && st_q.state == ST_RUN && core.ret && core.return_from_interrupt && !bus.wr && !ack
      |=> st_q.global_irq_enable)
    else $error("return-from-interrupt left enable clear");
  a_c_float: assert property (@(posedge clock)
    !resetn |-> port_c.oe == '0)
    else $error("port c driven during reset");
  a_ext_kept: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && st_q.external_irq_pending && !(bus.wr && bus.addr == REG_STATUS)
      |=> st_q.external_irq_pending)
    else $error("external pending cleared by hardware");
  a_tmr_kept: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && st_q.timer_irq_pending && !(bus.wr && bus.addr == REG_STATUS)
      |=> st_q.timer_irq_pending)
    else $error("timer pending cleared by hardware");
  a_timer_pend: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && timer_event |=> st_q.timer_irq_pending)
    else $error("timer event not latched");
  // lower bound only; the bench measures the full gap
  a_tick_gap: assert property (@(posedge clock) disable iff (!resetn)
    instr_tick |=> (!instr_tick) [*8] ##1 !instr_tick)
    else $error("instruction cycle shorter than ten clocks");
  a_push_low: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && tick && st_q.state == ST_SEQ && st_q.step == PUSH_LO_STEP
      |=> stack_wr.wr && stack_wr.addr == $past(stack_pointer))
    else $error("low byte push missing");
endmodule : mric_ctrl

/* File: mric_ctrl_tb_top.sv */
`timescale 1ns/1ps
module mric_ctrl_tb_top;
  import mric_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  mric_bus_t bus = '0;
  mric_core_req_t core = '{boundary: 1'b1, default: '0};
  mric_clk_opt_t clk_option = CLK_EXTERNAL;
  logic [7:0] port_l_in = 8'h00;
  logic [7:0] port_c_in = 8'h00;
  logic wake_pin;
  logic ext_pin;
  logic timer_event;
  logic [7:0] bus_rdata;
  logic [7:0] stack_pointer;
  logic [7:0] port_d;
  logic [14:0] program_counter;
  mric_stack_wr_t stack_wr;
  logic instr_tick;
  logic core_stall;
  logic halted;
  logic irq_request;
  mric_pins_t port_l;
  mric_pins_t port_g;
  mric_pins_t port_c;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  int k;
  int t;
  logic [15:0] sw [2];
  logic [3:0] clr_regs [9] = '{REG_L_DATA, REG_L_CFG, REG_G_DATA, REG_G_CFG, REG_C_DATA,
    REG_C_CFG, REG_STATUS, REG_CONTROL, REG_PROG_HI};

  always #5 clock = ~clock;

  mric_ctrl mric_ctrl_inst (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .bus(bus), .bus_rdata(bus_rdata),
    .core(core), .timer_event(timer_event), .program_counter(program_counter),
    .stack_pointer(stack_pointer), .stack_wr(stack_wr), .instr_tick(instr_tick),
    .core_stall(core_stall), .halted(halted), .irq_request(irq_request),
    .clk_option(clk_option), .clock_out_wake_pin(wake_pin), .port_l_in(port_l_in),
    .port_g_in({7'h00, ext_pin}), .port_c_in(port_c_in), .port_l(port_l), .port_g(port_g),
    .port_c(port_c), .port_d(port_d)
  );

  mric_src_model mric_src_model_inst (
    .clock(clock), .wake_pin(wake_pin), .ext_pin(ext_pin), .timer_event(timer_event)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // sample a little after the edge so registered outputs have settled
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock) bus <= '0;
  endtask : reg_wr

  task automatic expect_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock) bus <= '0;
    #1;
    chk(what, {8'h00, bus_rdata}, {8'h00, exp});
  endtask : expect_reg

  task automatic core_pulse(input mric_core_req_t c);
    @(posedge clock) core <= c;
    @(posedge clock) core <= '{boundary: 1'b1, default: '0};
  endtask : core_pulse

  // counts instruction ticks and stack writes while the core is stalled
  task automatic run_seq(output int ticks);
    ticks = 0;
    k = 0;
    for (n = 0; n < 30 && core_stall !== 1'b1; n++) step();
    for (n = 0; n < 120 && core_stall === 1'b1; n++) begin
      if (instr_tick === 1'b1) ticks++;
      if (stack_wr.wr === 1'b1 && k < 2) begin
        sw[k] = {stack_wr.addr, stack_wr.data};
        k++;
      end
      step();
    end
  endtask : run_seq

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    #1;
    chk("port_d", {8'h00, port_d}, 16'h00ff);
    chk("oe", {port_l.oe, port_g.oe | port_c.oe}, 16'h0000);
    @(posedge clock) resetn <= 1'b1;
    foreach (clr_regs[i]) expect_reg("cleared", clr_regs[i], 8'h00);
    expect_reg("d data", REG_D_DATA, 8'hff);
    chk("pc", {1'b0, program_counter}, 16'h0000);
    $display("done: reset");

    reg_wr(REG_G_CFG, 8'hff);
    expect_reg("g cfg", REG_G_CFG, 8'h3f);
    chk("g oe", {8'h00, port_g.oe}, 16'h003f);
    reg_wr(REG_L_CFG, 8'ha5);
    reg_wr(REG_L_DATA, 8'h3c);
    reg_wr(REG_C_DATA, 8'hff);
    reg_wr(REG_C_CFG, 8'hff);
    reg_wr(REG_D_DATA, 8'h00);
    step();
    chk("port_d run", {8'h00, port_d}, 16'h0000);
    chk("l pins", {port_l.out, port_l.oe}, 16'h3ca5);
    chk("c pins", {port_c.out, port_c.oe}, 16'h0f0f);
    // registers still hold their values here, so only the reset level floats the pins
    @(posedge clock) resetn <= 1'b0;
    #1;
    chk("port_d rerun", {8'h00, port_d}, 16'h00ff);
    chk("oe rerun", {port_l.oe, port_c.oe}, 16'h0000);
    @(posedge clock) resetn <= 1'b1;
    expect_reg("l cfg", REG_L_CFG, 8'h00);
    expect_reg("g cfg", REG_G_CFG, 8'h00);
    chk("outs", {port_l.out, port_c.out}, 16'h0000);
    $display("done: ports");

    reg_wr(REG_STACK, 8'h40);
    core_pulse('{prog_load: 1'b1, prog_value: 15'h1234, boundary: 1'b1, default: '0});
    reg_wr(REG_STATUS, 8'h02);
    mric_src_model_inst.set_ext(1'b1, 5);
    expect_reg("rise", REG_STATUS, 8'h0a);
    reg_wr(REG_STATUS, 8'h02);
    mric_src_model_inst.set_ext(1'b0, 5);
    expect_reg("fall", REG_STATUS, 8'h02);
    reg_wr(REG_CONTROL, 8'h02);
    mric_src_model_inst.set_ext(1'b1, 5);
    expect_reg("rise inv", REG_STATUS, 8'h02);
    mric_src_model_inst.set_ext(1'b0, 5);
    mric_src_model_inst.timer_pulse();
    expect_reg("pends", REG_STATUS, 8'h2a);
    chk("req off", {15'h0000, irq_request}, 16'h0000);
    reg_wr(REG_STATUS, 8'h2b);
    #1;
    chk("req on", {15'h0000, irq_request}, 16'h0001);
    run_seq(t);
    chk("ticks", t[15:0], 16'h0007);
    chk("push lo", sw[0], 16'h4034);
    chk("push hi", sw[1], 16'h3f12);
    chk("vector", {1'b0, program_counter}, 16'h00ff);
    chk("sp", {8'h00, stack_pointer}, 16'h003e);
    expect_reg("ack", REG_STATUS, 8'h2a);
    $display("done: interrupt");

    core_pulse('{ret: 1'b1, ret_value: 15'h1234, boundary: 1'b1, default: '0});
    step();
    chk("ret pc", {1'b0, program_counter}, 16'h1234);
    chk("ret sp", {8'h00, stack_pointer}, 16'h0040);
    expect_reg("ret", REG_STATUS, 8'h2a);
    reg_wr(REG_STATUS, 8'h00);
    core_pulse('{ret: 1'b1, return_from_interrupt: 1'b1, ret_value: 15'h1234, boundary: 1'b1, default: '0});
    expect_reg("return_from_interrupt", REG_STATUS, 8'h01);
    core_pulse('{soft_irq: 1'b1, boundary: 1'b1, default: '0});
    run_seq(t);
    chk("soft ticks", t[15:0], 16'h0007);
    chk("soft vector", {1'b0, program_counter}, 16'h00ff);
    chk("soft push", sw[1], 16'h4112);
    expect_reg("soft", REG_STATUS, 8'h01);
    $display("done: returns");

    for (n = 0; n < 12 && instr_tick !== 1'b1; n++) step();
    step();
    k = 1;
    while (k < 20 && instr_tick !== 1'b1) begin
      step();
      k++;
    end
    chk("tick gap", k[15:0], 16'h000a);
    $display("done: cycle");

    reg_wr(REG_G_DATA, 8'h80);
    repeat (2) step();
    chk("halted", {15'h0000, halted}, 16'h0001);
    chk("g out", {8'h00, port_g.out}, 16'h0080);
    k = 0;
    repeat (25) begin
      step();
      if (instr_tick === 1'b1) k++;
    end
    chk("halt ticks", k[15:0], 16'h0000);
    chk("halt pc", {1'b0, program_counter}, 16'h00ff);
    // crystal option owns the wake pin, so a rise must not resume
    @(posedge clock) clk_option <= CLK_CRYSTAL;
    mric_src_model_inst.wake(6);
    repeat (3) step();
    chk("crystal wake", {15'h0000, halted}, 16'h0001);
    @(posedge clock) clk_option <= CLK_EXTERNAL;
    mric_src_model_inst.wake(6);
    for (n = 0; n < 10 && halted !== 1'b0; n++) step();
    chk("woken", {15'h0000, halted}, 16'h0000);
    chk("wake pc", {1'b0, program_counter}, 16'h00ff);
    expect_reg("g data", REG_G_DATA, 8'h00);
    reg_wr(REG_G_DATA, 8'h80);
    repeat (3) step();
    @(posedge clock) resetn <= 1'b0;
    @(posedge clock) resetn <= 1'b1;
    step();
    chk("reset halt", {15'h0000, halted}, 16'h0000);
    chk("reset pc", {1'b0, program_counter}, 16'h0000);
    $display("done: halt");
    finish_test();
  end
endmodule : mric_ctrl_tb_top

/* File: mric_pkg.sv */
// Contract
// - input-only port g config bits ignore ones, read zero
// - setting port g bit seven data enters halt
// - port d drives all ones during reset
// - initialisation repeats whenever reset is held low
// - ports l, g, c float during initialisation
// - reset clears counter, status, control, port registers; port d data reloads all ones instead
// - halt freezes all activity and keeps state; pending flags and register writes still update while halted
// - reset while halted reinitialises, fetches from zero
// - wake pin rising edge resumes without reinitialising; code ignores the pin with the crystal option
// - wake resume clears port g bit seven data
// - sources: external edge, timer event, opcode zero
// - global enable gates both maskable sources
// - per-source enables select external and timer
// - maskable acknowledge clears global enable
// - edge select: zero rising, one falling
// - pending flags cleared only by software
// - global enable set again allows nesting
// - instruction cycle is clock divided by ten
// - acknowledge pushes, drops stack by two, vectors, seven cycles
// - software interrupt leaves global enable unchanged
// - return-from-interrupt pops and sets global enable
package mric_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 15;
  // register bus offsets
  localparam logic [3:0] REG_L_DATA = 4'h0;
  localparam logic [3:0] REG_L_CFG = 4'h1;
  localparam logic [3:0] REG_L_PINS = 4'h2;
  localparam logic [3:0] REG_G_DATA = 4'h3;
  localparam logic [3:0] REG_G_CFG = 4'h4;
  localparam logic [3:0] REG_G_PINS = 4'h5;
  localparam logic [3:0] REG_C_DATA = 4'h6;
  localparam logic [3:0] REG_C_CFG = 4'h7;
  localparam logic [3:0] REG_C_PINS = 4'h8;
  localparam logic [3:0] REG_D_DATA = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;
  localparam logic [3:0] REG_CONTROL = 4'hb;
  localparam logic [3:0] REG_STACK = 4'hc;
  localparam logic [3:0] REG_PROG_LO = 4'hd;
  localparam logic [3:0] REG_PROG_HI = 4'he;
  // processor status word fields
  localparam int ST_GLOBAL_EN = 0;
  localparam int ST_EXT_EN = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_EXT_PEND = 3;
  localparam int ST_TMR_EN = 4;
  localparam int ST_TMR_PEND = 5;
  // control word field
  localparam int CTL_EDGE_SEL = 1;
  // port layout
  localparam logic [7:0] INPUT_ONLY_MASK = 8'hc0;
  localparam logic [7:0] PORT_C_MASK = 8'h0f;
  localparam int WAKE_BIT = 7;
  localparam int EXT_PIN_BIT = 0;
  // reset and vector values
  localparam logic [7:0] PORT_D_RESET = 8'hff;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR = 15'h00ff;
  localparam logic [14:0] PROG_STEP = 15'h0001;
  localparam logic [7:0] STACK_STEP = 8'h02;
  localparam logic [7:0] BYTE_STEP = 8'h01;
  // timing
  localparam logic [3:0] CYCLE_DIV = 4'ha;
  localparam logic [3:0] DIV_LAST = CYCLE_DIV - 4'h1;
  localparam logic [2:0] SEQ_CYCLES = 3'h7;
  localparam logic [2:0] SEQ_LAST = SEQ_CYCLES - 3'h1;
  localparam logic [2:0] PUSH_LO_STEP = 3'h0;
  localparam logic [2:0] PUSH_HI_STEP = 3'h1;

  typedef enum logic [1:0] {
    CLK_CRYSTAL = 2'h0,
    CLK_EXTERNAL = 2'h1,
    CLK_RC = 2'h2
  } mric_clk_opt_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SEQ = 2'h1,
    ST_HALT = 2'h2
  } mric_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mric_bus_t;

  typedef struct packed {
    logic prog_inc;
    logic prog_load;
    logic [14:0] prog_value;
    logic ret;
    logic return_from_interrupt;
    logic [14:0] ret_value;
    logic soft_irq;
    logic boundary;
  } mric_core_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } mric_stack_wr_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } mric_pins_t;
endpackage : mric_pkg

/* File: mric_src_model.sv */
`timescale 1ns/1ps
module mric_src_model (
  // clock
  input wire logic clock,
  // source pins
  output logic wake_pin,
  output logic ext_pin,
  output logic timer_event
);
  initial begin
    wake_pin = 1'b0;
    ext_pin = 1'b0;
    timer_event = 1'b0;
  end

  // levels held several clocks so the two-flop sync sees each edge once
  task automatic set_ext(input logic lvl, input int hold);
    @(posedge clock) ext_pin <= lvl;
    repeat (hold) @(posedge clock);
  endtask : set_ext

  // slow sources pass a longer hold
  task automatic wake(input int hold);
    @(posedge clock) wake_pin <= 1'b1;
    repeat (hold) @(posedge clock);
    wake_pin <= 1'b0;
  endtask : wake

  task automatic timer_pulse();
    @(posedge clock) timer_event <= 1'b1;
    @(posedge clock) timer_event <= 1'b0;
  endtask : timer_pulse
endmodule : mric_src_model
